// ### hw/uart_ctrl_defs.svh
/*
 * Register offsets, field positions, reset values, interrupt codes and
 * trigger levels of the UART interrupt/FIFO/line control block.
 * Assumes it is included by bare name wherever these constants are needed.
 */
`ifndef UART_CTRL_DEFS_SVH
`define UART_CTRL_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_INTR_ID 8'h02
`define OFS_FIFO_CTRL 8'h02
`define OFS_LINE_CTRL 8'h03
`define READ_UNMAPPED 8'h00

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define INTR_ID_RESET 8'hC1
`define FIFO_CTRL_RESET 8'h00
`define LINE_CTRL_RESET 8'h00

// ----------------------------------------------------------------
// Interrupt identification codes, priority 1 first
// ----------------------------------------------------------------
`define INTR_CODE_RX_ERR 8'hC6
`define INTR_CODE_RX_AVAIL 8'hC4
`define INTR_CODE_RX_TMO 8'hCC
`define INTR_CODE_TX_EMPTY 8'hC2
`define INTR_CODE_MODEM 8'hC0
`define INTR_CODE_SPECIAL 8'hD0
`define INTR_CODE_FLOW 8'hE0
`define INTR_CODE_NONE 8'hC1
`define INTR_NONE_BIT 0
`define INTR_SRC_COUNT 7

// ----------------------------------------------------------------
// FIFO control fields
// ----------------------------------------------------------------
`define FCR_FIFO_EN 0
`define FCR_RX_FLUSH 1
`define FCR_TX_FLUSH 2
`define FCR_TX_TRIG 5:4
`define FCR_RX_TRIG 7:6
`define FCR_STORE_MASK 8'hF1

// ----------------------------------------------------------------
// Line control fields
// ----------------------------------------------------------------
`define LCR_LEN 1:0
`define LCR_STOP 2
`define LCR_PAR_EN 3
`define LCR_PAR_SEL 5:4
`define LCR_BREAK 6
`define LCR_DLAB 7
`define LEN_5BIT 2'h0
`define DATA_BITS_BASE 4'h5

// ----------------------------------------------------------------
// Stop length in half bit times
// ----------------------------------------------------------------
`define STOP_HALF_ONE 3'h2
`define STOP_HALF_ONE_HALF 3'h3
`define STOP_HALF_TWO 3'h4

// ----------------------------------------------------------------
// Trigger levels in entries
// ----------------------------------------------------------------
`define TX_TRIG_0 7'h10
`define TX_TRIG_1 7'h20
`define TX_TRIG_2 7'h40
`define TX_TRIG_3 7'h70
`define RX_TRIG_NE_0 7'h01
`define RX_TRIG_NE_1 7'h04
`define RX_TRIG_NE_2 7'h08
`define RX_TRIG_NE_3 7'h0E
`define RX_TRIG_EN_0 7'h0F
`define RX_TRIG_EN_1 7'h1F
`define RX_TRIG_EN_2 7'h3F
`define RX_TRIG_EN_3 7'h6F

`endif

// ### hw/uart_ctrl_pkg.sv
/*
 * Types shared by the UART control block and its buffer.
 * Assumes the constants header is available alongside.
 */
package uart_ctrl_pkg;

	// Parity selection, order follows the two select bits
	typedef enum logic [1:0] {
		PAR_ODD,
		PAR_EVEN,
		PAR_MARK,
		PAR_SPACE
	} parity_e;

	// Occupancy of the two-entry buffer
	typedef enum logic [1:0] {
		BUF_EMPTY,
		BUF_ONE,
		BUF_TWO
	} buf_state_e;

	typedef logic [7:0] byte_t;

endpackage

// ### hw/intr_priority_enc.sv
/*
 * Priority encoder for the interrupt identification code.
 * Assumes pending[0] is the highest priority source, all levels on clk domain.
 */
`timescale 1ns/100ps
`include "uart_ctrl_defs.svh"

module intr_priority_enc (
	input wire logic [`INTR_SRC_COUNT-1:0] pending,
	output uart_ctrl_pkg::byte_t code
);

	// Highest pending source wins
	always_comb begin
		if (pending[0]) begin
			code = `INTR_CODE_RX_ERR;
		end else if (pending[1]) begin
			code = `INTR_CODE_RX_AVAIL;
		end else if (pending[2]) begin
			code = `INTR_CODE_RX_TMO;
		end else if (pending[3]) begin
			code = `INTR_CODE_TX_EMPTY;
		end else if (pending[4]) begin
			code = `INTR_CODE_MODEM;
		end else if (pending[5]) begin
			code = `INTR_CODE_SPECIAL;
		end else if (pending[6]) begin
			code = `INTR_CODE_FLOW;
		end else begin
			code = `INTR_CODE_NONE;
		end
	end

endmodule // intr_priority_enc

// ### hw/skid_buffer.sv
/*
 * Two-entry buffer with valid/ready on both sides and a flush.
 * Assumes one clock, synchronous active-high reset and a clock enable.
 */
`timescale 1ns/100ps

module skid_buffer #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	uart_ctrl_pkg::buf_state_e state_q, state_d;
	logic [WIDTH-1:0] head_q, head_d;
	logic [WIDTH-1:0] tail_q, tail_d;
	logic push, pop;

	// Handshakes
	assign in_ready = (state_q != uart_ctrl_pkg::BUF_TWO);
	assign out_valid = (state_q != uart_ctrl_pkg::BUF_EMPTY);
	assign out_data = head_q;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Next occupancy and slot contents
	always_comb begin
		state_d = state_q;
		head_d = head_q;
		tail_d = tail_q;
		unique case (state_q)
			uart_ctrl_pkg::BUF_EMPTY: begin
				if (push) begin
					head_d = in_data;
					state_d = uart_ctrl_pkg::BUF_ONE;
				end
			end
			uart_ctrl_pkg::BUF_ONE: begin
				if (push && pop) begin
					head_d = in_data;
				end else if (push) begin
					tail_d = in_data;
					state_d = uart_ctrl_pkg::BUF_TWO;
				end else if (pop) begin
					state_d = uart_ctrl_pkg::BUF_EMPTY;
				end
			end
			uart_ctrl_pkg::BUF_TWO: begin
				if (pop) begin
					head_d = tail_q;
					state_d = uart_ctrl_pkg::BUF_ONE;
				end
			end
			default: begin
				state_d = uart_ctrl_pkg::BUF_EMPTY;
			end
		endcase
		if (flush) begin
			state_d = uart_ctrl_pkg::BUF_EMPTY;
		end
	end

	// Registers, frozen while ce is low
	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= uart_ctrl_pkg::BUF_EMPTY;
			head_q <= '0;
			tail_q <= '0;
		end else if (ce) begin
			state_q <= state_d;
			head_q <= head_d;
			tail_q <= tail_d;
		end
	end

endmodule // skid_buffer

// ### hw/uart_intr_fifo_line_ctrl.sv
/*
 * UART interrupt identification, FIFO control and line format control.
 * Holds the identification, FIFO control and line control registers,
 * drives the decoded configuration to the channel, and passes outgoing
 * characters through a two-entry buffer masked to the character length.
 * Assumes every input comes from logic on clk; registers are reached by
 * offset on the plain register port, reads answer one cycle later.
 */
//
// Behaviour
// - Identification read-only, resets C1h, bit0 idle high
// - Code shows only highest-priority pending source
// - FIFO control bit 0 enables FIFO mode
// - Bit 1 flushes receive FIFO, self-clears
// - Bit 2 flushes transmit FIFO, self-clears
// - Enhanced bits 5:4 pick transmit trigger level
// - Bits 7:6 pick receive trigger, mode-dependent table
// - Line bits 1:0 set five to eight data bits
`timescale 1ns/100ps
`include "uart_ctrl_defs.svh"

module uart_intr_fifo_line_ctrl (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic enhanced_mode,
	input wire logic src_rx_error,
	input wire logic src_rx_avail,
	input wire logic src_rx_timeout,
	input wire logic src_tx_empty,
	input wire logic src_modem,
	input wire logic src_special,
	input wire logic src_flow,
	output logic intr_pending,
	output logic fifo_enable,
	output logic rx_flush,
	output logic tx_flush,
	output logic [6:0] tx_trigger_level,
	output logic [6:0] rx_trigger_level,
	output logic [3:0] data_bits,
	output logic [2:0] stop_half_bits,
	output logic parity_enable,
	output uart_ctrl_pkg::parity_e parity_kind,
	output logic tx_break,
	output logic divisor_latch_sel,
	input wire logic char_in_valid,
	output logic char_in_ready,
	input wire logic [7:0] char_in_data,
	output logic char_out_valid,
	input wire logic char_out_ready,
	output logic [7:0] char_out_data
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------

	// Transmit trigger level from its code
	function automatic logic [6:0] tx_trig(input logic [1:0] sel);
		logic [6:0] lvl;
		unique case (sel)
			2'h0: lvl = `TX_TRIG_0;
			2'h1: lvl = `TX_TRIG_1;
			2'h2: lvl = `TX_TRIG_2;
			2'h3: lvl = `TX_TRIG_3;
		endcase
		return lvl;
	endfunction

	// Receive trigger level from its code and the mode
	function automatic logic [6:0] rx_trig(input logic [1:0] sel, input logic enh);
		logic [6:0] lvl;
		unique case (sel)
			2'h0: lvl = enh ? `RX_TRIG_EN_0 : `RX_TRIG_NE_0;
			2'h1: lvl = enh ? `RX_TRIG_EN_1 : `RX_TRIG_NE_1;
			2'h2: lvl = enh ? `RX_TRIG_EN_2 : `RX_TRIG_NE_2;
			2'h3: lvl = enh ? `RX_TRIG_EN_3 : `RX_TRIG_NE_3;
		endcase
		return lvl;
	endfunction

	// Keep only the low bits of a character of the set length
	function automatic logic [7:0] mask_char(input logic [7:0] data, input logic [1:0] len);
		logic [7:0] keep;
		keep = 8'hFF >> (2'h3 - len);
		return data & keep;
	endfunction

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0] fcr_q, fcr_d;
	logic [7:0] lcr_q, lcr_d;
	logic [7:0] id_q, id_d;
	logic [7:0] rdata_q, rdata_d;
	logic rx_flush_q, rx_flush_d;
	logic tx_flush_q, tx_flush_d;
	logic [6:0] tx_trig_q, tx_trig_d;
	logic [6:0] rx_trig_q, rx_trig_d;
	logic [3:0] bits_q, bits_d;
	logic [2:0] stop_q, stop_d;
	logic par_en_q, par_en_d;
	uart_ctrl_pkg::parity_e par_kind_q, par_kind_d;
	logic brk_q, brk_d;
	logic dlab_q, dlab_d;
	logic wr_fcr, wr_lcr;
	logic [`INTR_SRC_COUNT-1:0] pending;
	uart_ctrl_pkg::byte_t enc_code;

	// ----------------------------------------------------------------
	// Interrupt identification
	// ----------------------------------------------------------------

	// Sources in priority order, index 0 highest
	assign pending = {src_flow, src_special, src_modem, src_tx_empty,
		src_rx_timeout, src_rx_avail, src_rx_error};

	intr_priority_enc u_enc (
		.pending(pending),
		.code(enc_code)
	);

	assign id_d = enc_code;
	assign intr_pending = ~id_q[`INTR_NONE_BIT];

	// ----------------------------------------------------------------
	// Register access
	// ----------------------------------------------------------------
	assign wr_fcr = reg_wr && (reg_addr == `OFS_FIFO_CTRL);
	assign wr_lcr = reg_wr && (reg_addr == `OFS_LINE_CTRL);

	// Writes, flush pulses and read data
	always_comb begin
		fcr_d = fcr_q;
		lcr_d = lcr_q;
		rx_flush_d = 1'b0;
		tx_flush_d = 1'b0;
		rdata_d = rdata_q;
		if (wr_fcr) begin
			fcr_d = reg_wdata & `FCR_STORE_MASK;
			rx_flush_d = reg_wdata[`FCR_RX_FLUSH];
			tx_flush_d = reg_wdata[`FCR_TX_FLUSH];
		end
		if (wr_lcr) begin
			lcr_d = reg_wdata;
		end
		if (reg_rd) begin
			unique case (reg_addr)
				`OFS_INTR_ID: rdata_d = id_q;
				`OFS_LINE_CTRL: rdata_d = lcr_q;
				default: rdata_d = `READ_UNMAPPED;
			endcase
		end
	end

	// Register stage of the host-facing state
	always_ff @(posedge clk) begin
		if (reset) begin
			fcr_q <= `FIFO_CTRL_RESET;
			lcr_q <= `LINE_CTRL_RESET;
			id_q <= `INTR_ID_RESET;
			rdata_q <= `READ_UNMAPPED;
			rx_flush_q <= 1'b0;
			tx_flush_q <= 1'b0;
		end else if (ce) begin
			fcr_q <= fcr_d;
			lcr_q <= lcr_d;
			id_q <= id_d;
			rdata_q <= rdata_d;
			rx_flush_q <= rx_flush_d;
			tx_flush_q <= tx_flush_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign fifo_enable = fcr_q[`FCR_FIFO_EN];
	assign rx_flush = rx_flush_q;
	assign tx_flush = tx_flush_q;

	// ----------------------------------------------------------------
	// Decoded configuration
	// ----------------------------------------------------------------

	// Trigger levels and character format from the stored fields
	always_comb begin
		tx_trig_d = tx_trig(fcr_q[`FCR_TX_TRIG]);
		rx_trig_d = rx_trig(fcr_q[`FCR_RX_TRIG], enhanced_mode);
		bits_d = `DATA_BITS_BASE + {2'h0, lcr_q[`LCR_LEN]};
		if (!lcr_q[`LCR_STOP]) begin
			stop_d = `STOP_HALF_ONE;
		end else if (lcr_q[`LCR_LEN] == `LEN_5BIT) begin
			stop_d = `STOP_HALF_ONE_HALF;
		end else begin
			stop_d = `STOP_HALF_TWO;
		end
		par_en_d = lcr_q[`LCR_PAR_EN];
		par_kind_d = uart_ctrl_pkg::parity_e'(lcr_q[`LCR_PAR_SEL]);
		brk_d = lcr_q[`LCR_BREAK];
		dlab_d = lcr_q[`LCR_DLAB];
	end

	// Configuration outputs come from flops
	always_ff @(posedge clk) begin
		if (reset) begin
			tx_trig_q <= `TX_TRIG_0;
			rx_trig_q <= `RX_TRIG_NE_0;
			bits_q <= `DATA_BITS_BASE;
			stop_q <= `STOP_HALF_ONE;
			par_en_q <= 1'b0;
			par_kind_q <= uart_ctrl_pkg::PAR_ODD;
			brk_q <= 1'b0;
			dlab_q <= 1'b0;
		end else if (ce) begin
			tx_trig_q <= tx_trig_d;
			rx_trig_q <= rx_trig_d;
			bits_q <= bits_d;
			stop_q <= stop_d;
			par_en_q <= par_en_d;
			par_kind_q <= par_kind_d;
			brk_q <= brk_d;
			dlab_q <= dlab_d;
		end
	end

	assign tx_trigger_level = tx_trig_q;
	assign rx_trigger_level = rx_trig_q;
	assign data_bits = bits_q;
	assign stop_half_bits = stop_q;
	assign parity_enable = par_en_q;
	assign parity_kind = par_kind_q;
	assign tx_break = brk_q;
	assign divisor_latch_sel = dlab_q;

	// ----------------------------------------------------------------
	// Outgoing character path
	// ----------------------------------------------------------------

	// Characters masked to length, emptied by the transmit flush
	skid_buffer #(
		.WIDTH(8)
	) u_buf (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.flush(tx_flush_q),
		.in_valid(char_in_valid),
		.in_ready(char_in_ready),
		.in_data(mask_char(char_in_data, lcr_q[`LCR_LEN])),
		.out_valid(char_out_valid),
		.out_ready(char_out_ready),
		.out_data(char_out_data)
	);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_id_none;
		(ce && (pending == '0)) |=> ($stable(reg_rdata) || $past(reg_rd)) && (intr_pending == 1'b0)
			&& (id_q == `INTR_CODE_NONE);
	endproperty
	a_id_none: assert property (p_id_none) else $error("idle code not C1h");

	property p_id_read;
		(ce && reg_rd && (reg_addr == `OFS_INTR_ID)) |=> (reg_rdata == $past(id_q));
	endproperty
	a_id_read: assert property (p_id_read) else $error("identification read wrong");

	property p_id_top;
		(ce && src_rx_error) |=> (id_q == `INTR_CODE_RX_ERR) && intr_pending;
	endproperty
	a_id_top: assert property (p_id_top) else $error("top source not reported");

	property p_id_low;
		(ce && (pending == 7'h40)) |=> (id_q == `INTR_CODE_FLOW);
	endproperty
	a_id_low: assert property (p_id_low) else $error("lowest source code wrong");

	property p_fifo_en;
		(ce && wr_fcr) |=> (fifo_enable == $past(reg_wdata[`FCR_FIFO_EN]));
	endproperty
	a_fifo_en: assert property (p_fifo_en) else $error("FIFO enable not stored");

	property p_rx_flush;
		(ce && wr_fcr && reg_wdata[`FCR_RX_FLUSH]) ##1 (ce && !wr_fcr) |-> rx_flush ##1 !rx_flush;
	endproperty
	a_rx_flush: assert property (p_rx_flush) else $error("receive flush not one pulse");

	property p_tx_flush;
		(ce && tx_flush) |=> !char_out_valid && !tx_flush;
	endproperty
	a_tx_flush: assert property (p_tx_flush) else $error("transmit flush left data");

	property p_tx_trig;
		(ce && wr_fcr && (reg_wdata[`FCR_TX_TRIG] == 2'h3)) ##1 ce |=> (tx_trigger_level == `TX_TRIG_3);
	endproperty
	a_tx_trig: assert property (p_tx_trig) else $error("transmit trigger wrong");

	property p_rx_trig;
		(ce && (fcr_q[`FCR_RX_TRIG] == 2'h3)) |=>
			(rx_trigger_level == ($past(enhanced_mode) ? `RX_TRIG_EN_3 : `RX_TRIG_NE_3));
	endproperty
	a_rx_trig: assert property (p_rx_trig) else $error("receive trigger wrong");

	property p_len;
		(ce && wr_lcr && (reg_wdata[`LCR_LEN] == `LEN_5BIT)) ##1 ce |=> (data_bits == `DATA_BITS_BASE);
	endproperty
	a_len: assert property (p_len) else $error("data length wrong");

	property p_stop;
		(ce && lcr_q[`LCR_STOP] && (lcr_q[`LCR_LEN] == `LEN_5BIT)) |=> (stop_half_bits == `STOP_HALF_ONE_HALF);
	endproperty
	a_stop: assert property (p_stop) else $error("stop length wrong");

	property p_break;
		(ce && wr_lcr) ##1 ce |=> (tx_break == $past(reg_wdata[`LCR_BREAK], 2))
			&& (divisor_latch_sel == $past(reg_wdata[`LCR_DLAB], 2));
	endproperty
	a_break: assert property (p_break) else $error("break or latch select wrong");

	// Main scenarios
	c_flow_only: cover property (ce && (pending == 7'h40) ##1 (id_q == `INTR_CODE_FLOW));
	c_buf_full: cover property (char_out_valid && !char_in_ready);
	c_flush_full: cover property (!char_in_ready ##1 tx_flush);
	c_enh_trig: cover property (enhanced_mode && (rx_trigger_level == `RX_TRIG_EN_3));

endmodule // uart_intr_fifo_line_ctrl

// ### dv/char_sink_model.sv
/*
 * Far-side model: the remote serial device that takes characters off the
 * outgoing buffer, at a random pace, and keeps every character it took.
 * Assumes it shares clk and the synchronous active-high reset with the block.
 */
`timescale 1ns/100ps

module char_sink_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic stall,
	input wire logic char_out_valid,
	input wire logic [7:0] char_out_data,
	output logic char_out_ready
);
	// ----------------------------------------------------------------
	// Receive side
	// ----------------------------------------------------------------
	uart_ctrl_pkg::byte_t got[$];

	// Take on valid and ready; ready moves only after an edge
	always @(posedge clk) begin
		if (reset) begin
			char_out_ready <= 1'b0;
		end else begin
			if (char_out_valid && char_out_ready) begin
				got.push_back(char_out_data);
			end
			char_out_ready <= !stall && ($urandom_range(0, 3) != 0); // Slow and prompt
		end
	end
endmodule // char_sink_model

// ### dv/uart_intr_fifo_line_ctrl_tb_top.sv
/*
 * Self-checking bench: identification priority, FIFO control, line
 * control and the outgoing character buffer against a stalling sink.
 * Assumes the design package, header and the sink model are compiled first.
 */
`timescale 1ns/100ps
`include "uart_ctrl_defs.svh"

module uart_intr_fifo_line_ctrl_tb_top;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic ce = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic enhanced_mode = 1'b0;
	logic [6:0] src = 7'h00;
	logic intr_pending, fifo_enable, rx_flush, tx_flush, parity_enable, tx_break, divisor_latch_sel;
	logic [6:0] tx_trigger_level, rx_trigger_level;
	logic [3:0] data_bits;
	logic [2:0] stop_half_bits;
	uart_ctrl_pkg::parity_e parity_kind;
	logic char_in_valid = 1'b0;
	logic char_in_ready, char_out_valid, char_out_ready;
	logic [7:0] char_in_data = 8'h00;
	logic [7:0] char_out_data;
	logic stall = 1'b0;
	int n_fail = 0;
	int comparisons = 0;
	uart_ctrl_pkg::byte_t exp_q[$];
	localparam logic [7:0] codes [7] = '{8'hC6, 8'hC4, 8'hCC, 8'hC2, 8'hC0, 8'hD0, 8'hE0};
	localparam logic [6:0] tx_tab [4] = '{7'h10, 7'h20, 7'h40, 7'h70};
	localparam logic [6:0] rx_ne [4] = '{7'h01, 7'h04, 7'h08, 7'h0E};
	localparam logic [6:0] rx_en [4] = '{7'h0F, 7'h1F, 7'h3F, 7'h6F};

	// Clock, 100 ns period
	always #50 clk = ~clk;

	uart_intr_fifo_line_ctrl u_dut (.clk, .reset, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.enhanced_mode, .src_rx_error(src[0]), .src_rx_avail(src[1]), .src_rx_timeout(src[2]),
		.src_tx_empty(src[3]), .src_modem(src[4]), .src_special(src[5]), .src_flow(src[6]),
		.intr_pending, .fifo_enable, .rx_flush, .tx_flush, .tx_trigger_level, .rx_trigger_level,
		.data_bits, .stop_half_bits, .parity_enable, .parity_kind, .tx_break, .divisor_latch_sel,
		.char_in_valid, .char_in_ready, .char_in_data, .char_out_valid, .char_out_ready, .char_out_data);

	char_sink_model u_sink (.clk, .reset, .stall, .char_out_valid, .char_out_data, .char_out_ready);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] exp_code(input logic [6:0] s);
		for (int i = 0; i < 7; i++) begin
			if (s[i]) begin
				return codes[i];
			end
		end
		return 8'hC1;
	endfunction

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Write strobe for one cycle; returns just after the taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// Valid held until ready is seen high at a taking edge
	task automatic push(input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		char_in_valid <= 1'b1;
		char_in_data <= d;
		@(negedge clk);
		while (!char_in_ready && n < 200) begin
			@(negedge clk);
			n++;
		end
		check("in_ready", {7'h00, char_in_ready}, 8'h01);
		@(posedge clk);
		char_in_valid <= 1'b0;
	endtask

	task automatic wrap_up();
		if (n_fail == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		wrap_up();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] d, v, m;
		logic em;
		void'($urandom(32'hF488E454));
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		// Reset values
		rd(`OFS_INTR_ID, v);
		check("ident", v, 8'hC1);
		check("pending", {7'h00, intr_pending}, 8'h00);
		check("fifo_en", {7'h00, fifo_enable}, 8'h00);
		check("tx_trig", {1'b0, tx_trigger_level}, 8'h10);
		check("rx_trig", {1'b0, rx_trigger_level}, 8'h01);
		check("bits", {4'h0, data_bits}, 8'h05);
		check("stop", {5'h00, stop_half_bits}, 8'h02);
		check("par", {4'h0, tx_break, divisor_latch_sel, parity_enable, parity_kind == 2'h0}, 8'h01);
		rd(`OFS_LINE_CTRL, v);
		check("lcr", v, 8'h00);
		// Single sources, then random mixes
		for (int i = 0; i < 40; i++) begin
			v = (i < 7) ? (8'h01 << i) : ((i == 7) ? 8'h00 : 8'($urandom));
			@(posedge clk);
			src <= v[6:0];
			rd(`OFS_INTR_ID, d);
			check("ident", d, exp_code(v[6:0]));
			check("pending", {7'h00, intr_pending}, {7'h00, |v[6:0]});
		end
		// FIFO control writes, all trigger codes in both modes
		for (int i = 0; i < 24; i++) begin
			d = (i < 8) ? {i[1:0], i[1:0], 1'b0, i[2:0]} : 8'($urandom);
			em = (i < 8) ? i[2] : 1'($urandom);
			@(posedge clk);
			enhanced_mode <= em;
			wr(`OFS_FIFO_CTRL, d);
			check("fifo_en", {7'h00, fifo_enable}, {7'h00, d[0]});
			check("rx_flush", {7'h00, rx_flush}, {7'h00, d[1]});
			check("tx_flush", {7'h00, tx_flush}, {7'h00, d[2]});
			@(posedge clk);
			#1;
			check("flush_clr", {6'h00, rx_flush, tx_flush}, 8'h00);
			check("tx_trig", {1'b0, tx_trigger_level}, {1'b0, tx_tab[d[5:4]]});
			check("rx_trig", {1'b0, rx_trigger_level}, {1'b0, em ? rx_en[d[7:6]] : rx_ne[d[7:6]]});
			rd(`OFS_INTR_ID, v);
			check("ident_ro", v, exp_code(src));
		end
		// Line control, every length, stop and parity code
		for (int i = 0; i < 16; i++) begin
			d = 8'($urandom);
			d[3:0] = i[3:0];
			d[5:4] = i[1:0];
			wr(`OFS_LINE_CTRL, d);
			@(posedge clk);
			#1;
			check("bits", {4'h0, data_bits}, 8'h05 + d[1:0]);
			check("stop", {5'h00, stop_half_bits}, !d[2] ? 8'h02 : (d[1:0] == 2'h0 ? 8'h03 : 8'h04));
			check("par", {2'h0, divisor_latch_sel, tx_break, parity_kind, parity_enable, 1'b0}, {2'h0, d[7:6], d[5:3], 1'b0});
			rd(`OFS_LINE_CTRL, v);
			check("lcr", v, d);
		end
		// Unmapped offset, then a write while frozen
		rd(8'h05, v);
		check("unmapped", v, 8'h00);
		@(posedge clk);
		ce <= 1'b0;
		wr(`OFS_LINE_CTRL, ~d);
		@(posedge clk);
		ce <= 1'b1;
		rd(`OFS_LINE_CTRL, v);
		check("lcr_frozen", v, d);
		// Stream through buffer at every length, sink pacing randomly
		for (int len = 0; len < 4; len++) begin
			wr(`OFS_LINE_CTRL, {6'h00, len[1:0]});
			m = 8'((9'h020 << len[1:0]) - 9'h001);
			for (int k = 0; k < 10; k++) begin
				v = (k == 0) ? 8'hFF : 8'($urandom);
				exp_q.push_back(v & m);
				push(v);
			end
			for (int n = 0; n < 200 && u_sink.got.size() < exp_q.size(); n++) begin
				@(posedge clk);
			end
			check("count", 8'(u_sink.got.size()), 8'(exp_q.size()));
			foreach (exp_q[k]) begin
				check("char", u_sink.got[k], exp_q[k]);
			end
			exp_q.delete();
			u_sink.got.delete();
		end
		// Fill while the sink stalls, then flush the transmit side
		@(posedge clk);
		stall <= 1'b1;
		repeat (3) @(posedge clk);
		push(8'h11);
		push(8'h22);
		@(negedge clk);
		check("full", {6'h00, char_in_ready, char_out_valid}, 8'h01);
		wr(`OFS_FIFO_CTRL, 8'h04);
		check("tx_flush", {7'h00, tx_flush}, 8'h01);
		@(posedge clk);
		#1;
		check("flushed", {5'h00, tx_flush, char_in_ready, char_out_valid}, 8'h02);
		wrap_up();
	end
endmodule // uart_intr_fifo_line_ctrl_tb_top
